// ### logic/seq_host_end.sv
// Purpose: Host end: serial port master plus the boot, soft reset and setup sequence.
// Assumes: One chain on this select; the device shares rst with this end.
// Notes: The host cannot see boot completion, so it waits the exit delay plus a margin.
`timescale 1ns/1ns
module seq_host_end
    import seq_pkg::*;
#(
    parameter int unsigned EXIT_CYCLES = EXIT_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    host_link_if.host link,
    input wire logic [UNIT_W-1:0] unit_id_cfg,
    input wire logic soft_reset_req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_rw,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    output logic resp_valid,
    output logic resp_refused,
    output logic [15:0] resp_rdata,
    output logic dev_ready
);
    typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH, E_GAP} eng_state_t;
    typedef enum logic [2:0] {H_WAIT, H_EYE, H_UNIT_OFF, H_UNIT_SET, H_IDLE, H_USER, H_RESET} host_state_t;

    localparam logic [EXIT_CNT_W-1:0] WAIT_LAST = EXIT_CNT_W'(EXIT_CYCLES + HOST_WAIT_MARGIN - 1);
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
    localparam logic [7:0] GAP_LAST = 8'(CMD_GAP_CYCLES - 1);
    localparam logic [5:0] FRAME_LAST = 6'(FRAME_BITS - 1);
    localparam logic [5:0] DATA_FIRST = 6'(DATA_FIRST_BIT);

    eng_state_t eng_q;
    host_state_t hst_q;
    logic [47:0] tx_q;
    logic [5:0] bit_q;
    logic [7:0] tick_q;
    logic [15:0] rx_q;
    logic sclk_q;
    logic cs_n_q;
    logic sdin_q;
    logic [1:0] dout_sy_q;
    logic go;
    logic eng_done;
    logic f_rw;
    logic [UNIT_W-1:0] f_unit;
    logic [15:0] f_addr;
    logic [15:0] f_data;
    logic [EXIT_CNT_W-1:0] wait_q;
    logic [UNIT_W-1:0] unit_cfg_q;
    logic [UNIT_W-1:0] cur_unit_q;
    logic u_rw_q;
    logic [15:0] u_addr_q;
    logic [15:0] u_wdata_q;
    logic take;
    logic refuse;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dout_sy_q <= 2'h3;
        end else begin
            dout_sy_q <= {dout_sy_q[0], link.sdout};
        end
    end

    // Serial engine: one 48-bit frame, data out read at the end of each high phase from bit 32 on.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eng_q <= E_IDLE;
            tx_q <= 48'h000000000000;
            bit_q <= 6'h00;
            tick_q <= 8'h00;
            rx_q <= 16'h0000;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            sdin_q <= 1'b1;
        end else begin
            case (eng_q)
                E_IDLE: begin
                    if (go) begin
                        tx_q <= {f_rw, 2'b00, 1'b0, f_unit, 7'h00, f_addr, f_data};
                        sdin_q <= f_rw;
                        cs_n_q <= 1'b0;
                        bit_q <= 6'h00;
                        tick_q <= 8'h00;
                        eng_q <= E_LOW;
                    end
                end
                E_LOW: begin
                    if (tick_q == HALF_LAST) begin
                        tick_q <= 8'h00;
                        sclk_q <= 1'b1;
                        eng_q <= E_HIGH;
                    end else begin
                        tick_q <= tick_q + 8'h01;
                    end
                end
                E_HIGH: begin
                    if (tick_q == HALF_LAST) begin
                        tick_q <= 8'h00;
                        sclk_q <= 1'b0;
                        if (bit_q >= DATA_FIRST) begin
                            rx_q <= {rx_q[14:0], dout_sy_q[1]};
                        end
                        if (bit_q == FRAME_LAST) begin
                            cs_n_q <= 1'b1;
                            sdin_q <= 1'b1;
                            eng_q <= E_GAP;
                        end else begin
                            tx_q <= {tx_q[46:0], 1'b0};
                            sdin_q <= tx_q[46];
                            bit_q <= bit_q + 6'h01;
                            eng_q <= E_LOW;
                        end
                    end else begin
                        tick_q <= tick_q + 8'h01;
                    end
                end
                E_GAP: begin
                    if (tick_q == GAP_LAST) begin
                        tick_q <= 8'h00;
                        eng_q <= E_IDLE;
                    end else begin
                        tick_q <= tick_q + 8'h01;
                    end
                end
                default: eng_q <= E_IDLE;
            endcase
        end
    end

    assign eng_done = (eng_q == E_GAP) && (tick_q == GAP_LAST);
    assign go = (eng_q == E_IDLE) && (hst_q != H_WAIT) && (hst_q != H_IDLE);

    always_comb begin
        f_rw = 1'b0;
        f_unit = cur_unit_q;
        f_addr = ADDR_CHAIN_CTRL;
        f_data = 16'h0000;
        case (hst_q)
            H_EYE: begin
                f_addr = ADDR_EYE_CFG3;
                f_data = EYE_CFG3_BOOT_VALUE;
            end
            H_UNIT_OFF: f_data = CTRL_LINK_DIS_MASK;
            H_UNIT_SET: f_data = {11'h000, unit_cfg_q};
            H_RESET: begin
                f_addr = ADDR_SOFT_RESET;
                f_data = RST_PULSE;
            end
            H_USER: begin
                f_rw = u_rw_q;
                f_addr = u_addr_q;
                f_data = u_wdata_q;
            end
            default: f_rw = 1'b0;
        endcase
    end

    assign req_ready = (hst_q == H_IDLE) && !soft_reset_req;
    assign take = req_valid && req_ready;
    assign refuse = !req_rw && (req_addr >= ADDR_INTERNAL_LO) && (req_addr <= ADDR_INTERNAL_HI);

    // The port stays silent for the whole wait, after power-on and after a soft reset alike.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_q <= '0;
        end else if (hst_q == H_WAIT) begin
            wait_q <= wait_q + 1'b1;
        end else begin
            wait_q <= '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hst_q <= H_WAIT;
        end else begin
            case (hst_q)
                H_WAIT: if (wait_q == WAIT_LAST) hst_q <= H_EYE;
                H_EYE: if (eng_done) hst_q <= (unit_cfg_q != '0) ? H_UNIT_OFF : H_IDLE;
                H_UNIT_OFF: if (eng_done) hst_q <= H_UNIT_SET;
                H_UNIT_SET: if (eng_done) hst_q <= H_IDLE;
                H_IDLE: begin
                    if (soft_reset_req) begin
                        hst_q <= H_RESET;
                    end else if (take && !refuse) begin
                        hst_q <= H_USER;
                    end
                end
                H_USER: if (eng_done) hst_q <= H_IDLE;
                H_RESET: if (eng_done) hst_q <= H_WAIT;
                default: hst_q <= H_WAIT;
            endcase
        end
    end

    // Unit id is sampled during every wait, so a reset chain is readdressed on the way back up.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unit_cfg_q <= '0;
            cur_unit_q <= '0;
        end else if (hst_q == H_WAIT) begin
            unit_cfg_q <= unit_id_cfg;
        end else if ((hst_q == H_UNIT_SET) && eng_done) begin
            cur_unit_q <= unit_cfg_q;
        end else if ((hst_q == H_RESET) && eng_done) begin
            cur_unit_q <= '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            u_rw_q <= 1'b0;
            u_addr_q <= 16'h0000;
            u_wdata_q <= 16'h0000;
        end else if (take) begin
            u_rw_q <= req_rw;
            u_addr_q <= req_addr;
            u_wdata_q <= req_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_refused <= 1'b0;
            resp_rdata <= 16'h0000;
        end else begin
            resp_valid <= 1'b0;
            if (take && refuse) begin
                resp_valid <= 1'b1;
                resp_refused <= 1'b1;
            end else if ((hst_q == H_USER) && eng_done) begin
                resp_valid <= 1'b1;
                resp_refused <= 1'b0;
                resp_rdata <= u_rw_q ? rx_q : 16'h0000;
            end
        end
    end

    assign dev_ready = (hst_q == H_IDLE) || (hst_q == H_USER);
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.sdin = sdin_q;
endmodule : seq_host_end

// ### logic/seq_pkg.sv
// Purpose: Shared constants for the boot and soft reset sequencer ends.
// Assumes: 20 MHz system clock on both ends.
// Notes: Command word 1 layout is rw, two spare bits, auto-increment, unit id, upper address.
package seq_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned EXIT_DELAY_MS = 5;
    localparam int unsigned EXIT_CYCLES_DEF = EXIT_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned EXIT_CNT_W = 18;
    localparam int unsigned HOST_WAIT_MARGIN = 64;
    localparam int unsigned SCLK_HALF = 16;
    localparam int unsigned CMD_GAP_SCLKS = 3;
    localparam int unsigned CMD_GAP_CYCLES = CMD_GAP_SCLKS * 2 * SCLK_HALF;
    localparam int unsigned FRAME_BITS = 48;
    localparam int unsigned DATA_FIRST_BIT = 32;
    localparam int unsigned REG_COUNT = 127;

    localparam logic [15:0] ADDR_CHAIN_CTRL = 16'h0000;
    localparam logic [15:0] ADDR_EYE_CFG3 = 16'h0057;
    localparam logic [15:0] ADDR_INTERNAL_LO = 16'h0060;
    localparam logic [15:0] ADDR_INTERNAL_HI = 16'h007E;
    localparam logic [15:0] ADDR_SOFT_RESET = 16'h007F;

    localparam logic [15:0] EYE_CFG3_BOOT_VALUE = 16'h8006;
    localparam logic [15:0] RST_PULSE = 16'hAD00;
    localparam logic [15:0] RST_HOLD = 16'hAA00;
    localparam logic [15:0] RST_RELEASE = 16'hDD00;
    localparam logic [15:0] REG_RESET = 16'h0000;

    localparam int unsigned CTRL_LINK_DIS_BIT = 14;
    localparam int unsigned CTRL_BUS_THRU_BIT = 13;
    localparam int unsigned UNIT_W = 5;
    localparam logic [15:0] CTRL_LINK_DIS_MASK = 16'h4000;

    localparam int unsigned CMD_RW_BIT = 15;
    localparam int unsigned CMD_AUTOINC_BIT = 12;
    localparam int unsigned CMD_UNIT_LSB = 7;
    localparam int unsigned CMD_ADDR_HI_W = 7;

    typedef enum logic [1:0] {PH_CMD1, PH_CMD2, PH_DATA} word_phase_t;
endpackage : seq_pkg

// ### logic/host_link_if.sv
// Purpose: Serial control port wires between host end and device end.
// Assumes: Host drives clock, select and data in; device drives data out.
// Notes: Data out is push-pull, so no enable is carried.
`timescale 1ns/1ns
interface host_link_if;
    logic sclk;
    logic cs_n;
    logic sdin;
    logic sdout;
    modport device (input sclk, input cs_n, input sdin, output sdout);
    modport host (output sclk, output cs_n, output sdin, input sdout);
endinterface : host_link_if

// ### logic/seq_device_end.sv
// Purpose: Device end: serial port slave, register file, soft reset and boot exit delay.
// Assumes: rst is the power-on reset, released once the supply is good.
// Notes: Loop-through passes data in through the input synchroniser to data out, so it is clocked here.
`timescale 1ns/1ns
module seq_device_end
    import seq_pkg::*;
#(
    parameter int unsigned EXIT_CYCLES = EXIT_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    host_link_if.device link,
    output logic core_rst,
    output logic core_ready,
    output logic [UNIT_W-1:0] unit_id,
    output logic link_disable,
    output logic bus_through,
    output logic [15:0] eye_cfg
);
    typedef enum logic [1:0] {ST_BOOT, ST_READY, ST_HELD} dev_state_t;

    localparam logic [EXIT_CNT_W-1:0] EXIT_LAST = EXIT_CNT_W'(EXIT_CYCLES - 1);

    logic [2:0] sclk_sy_q;
    logic [1:0] cs_sy_q;
    logic [1:0] din_sy_q;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_act;
    logic [15:0] sh_q;
    logic [3:0] bit_q;
    word_phase_t word_q;
    logic [15:0] cmd1_q;
    logic [15:0] addr_q;
    logic [15:0] sh_next;
    logic word_done;
    logic unit_ok;
    logic wr_stb;
    logic rst_wr;
    logic rd_load;
    logic [15:0] rd_addr;
    logic [15:0] rd_data;
    logic [15:0] rd_sh_q;
    logic rd_act_q;
    logic sdout_q;
    dev_state_t state_q;
    logic [EXIT_CNT_W-1:0] cnt_q;
    logic [15:0] regs_q [0:REG_COUNT-1];

    function automatic logic hits_map(input logic [15:0] c1, input logic [15:0] a);
        hits_map = (c1[CMD_ADDR_HI_W-1:0] == 7'h00) && (a <= ADDR_SOFT_RESET);
    endfunction : hits_map

    // Only the reset register stays reachable while held; nothing is reachable during boot.
    function automatic logic may_access(input dev_state_t s, input logic [15:0] a);
        may_access = (s == ST_READY) || ((s == ST_HELD) && (a == ADDR_SOFT_RESET));
    endfunction : may_access

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_sy_q <= 3'h0;
            cs_sy_q <= 2'h3;
            din_sy_q <= 2'h3;
        end else begin
            sclk_sy_q <= {sclk_sy_q[1:0], link.sclk};
            cs_sy_q <= {cs_sy_q[0], link.cs_n};
            din_sy_q <= {din_sy_q[0], link.sdin};
        end
    end

    assign sclk_rise = sclk_sy_q[1] & ~sclk_sy_q[2];
    assign sclk_fall = ~sclk_sy_q[1] & sclk_sy_q[2];
    assign frame_act = ~cs_sy_q[1];
    assign sh_next = {sh_q[14:0], din_sy_q[1]};
    assign word_done = frame_act & sclk_rise & (bit_q == 4'hF);

    // Word receiver: select high clears the framing, so each frame starts at command word 1.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sh_q <= 16'h0000;
            bit_q <= 4'h0;
            word_q <= PH_CMD1;
            cmd1_q <= 16'h0000;
            addr_q <= 16'h0000;
        end else if (!frame_act) begin
            bit_q <= 4'h0;
            word_q <= PH_CMD1;
        end else if (sclk_rise) begin
            sh_q <= sh_next;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'hF) begin
                case (word_q)
                    PH_CMD1: begin
                        cmd1_q <= sh_next;
                        word_q <= PH_CMD2;
                    end
                    PH_CMD2: begin
                        addr_q <= sh_next;
                        word_q <= PH_DATA;
                    end
                    default: begin
                        if (cmd1_q[CMD_AUTOINC_BIT]) begin
                            addr_q <= addr_q + 16'h0001;
                        end
                    end
                endcase
            end
        end
    end

    assign unit_ok = (cmd1_q[CMD_UNIT_LSB +: UNIT_W] == unit_id);
    assign wr_stb = word_done && (word_q == PH_DATA) && !cmd1_q[CMD_RW_BIT] && unit_ok
        && hits_map(cmd1_q, addr_q) && may_access(state_q, addr_q);
    assign rst_wr = wr_stb && (addr_q == ADDR_SOFT_RESET);
    assign rd_load = word_done && cmd1_q[CMD_RW_BIT] && unit_ok
        && ((word_q == PH_CMD2) || ((word_q == PH_DATA) && cmd1_q[CMD_AUTOINC_BIT]));
    assign rd_addr = (word_q == PH_CMD2) ? sh_next : addr_q + 16'h0001;

    always_comb begin
        rd_data = 16'h0000;
        if (hits_map(cmd1_q, rd_addr) && may_access(state_q, rd_addr)) begin
            if (rd_addr == ADDR_SOFT_RESET) begin
                rd_data = (state_q == ST_HELD) ? RST_HOLD : RST_RELEASE;
            end else begin
                rd_data = regs_q[rd_addr[6:0]];
            end
        end
    end

    // Reset state machine; the pulse code goes straight to boot so assert and release fit in one word.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_BOOT;
        end else begin
            case (state_q)
                ST_BOOT: begin
                    if (cnt_q == EXIT_LAST) begin
                        state_q <= ST_READY;
                    end
                end
                ST_READY, ST_HELD: begin
                    if (rst_wr) begin
                        case (sh_next)
                            RST_PULSE: state_q <= ST_BOOT;
                            RST_HOLD: state_q <= ST_HELD;
                            RST_RELEASE: begin
                                if (state_q == ST_HELD) begin
                                    state_q <= ST_BOOT;
                                end
                            end
                            default: state_q <= state_q;
                        endcase
                    end
                end
                default: state_q <= ST_BOOT;
            endcase
        end
    end

    // The counter rests at zero outside boot, so every entry to boot gets the full delay.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (state_q == ST_BOOT) begin
            cnt_q <= cnt_q + 1'b1;
        end else begin
            cnt_q <= '0;
        end
    end

    // Everything outside ready is reset state, which also restores unit zero and loop-through.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (state_q != ST_READY) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (wr_stb && (addr_q != ADDR_SOFT_RESET)) begin
            regs_q[addr_q[6:0]] <= sh_next;
        end
    end

    // Read data leaves on falling edges so the host can take it a full period later.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_sh_q <= 16'h0000;
            rd_act_q <= 1'b0;
        end else if (!frame_act) begin
            rd_act_q <= 1'b0;
        end else if (rd_load) begin
            rd_sh_q <= rd_data;
            rd_act_q <= 1'b1;
        end else if (rd_act_q && sclk_fall) begin
            rd_sh_q <= {rd_sh_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sdout_q <= 1'b1;
        end else if (rd_act_q) begin
            if (sclk_fall) begin
                sdout_q <= rd_sh_q[15];
            end
        end else begin
            sdout_q <= link_disable ? 1'b1 : din_sy_q[1];
        end
    end

    assign link.sdout = sdout_q;
    assign core_ready = (state_q == ST_READY);
    assign core_rst = (state_q != ST_READY);
    assign unit_id = regs_q[ADDR_CHAIN_CTRL[6:0]][UNIT_W-1:0];
    assign link_disable = regs_q[ADDR_CHAIN_CTRL[6:0]][CTRL_LINK_DIS_BIT];
    assign bus_through = regs_q[ADDR_CHAIN_CTRL[6:0]][CTRL_BUS_THRU_BIT];
    assign eye_cfg = regs_q[ADDR_EYE_CFG3[6:0]];
endmodule : seq_device_end

// ### verification/seq_link_sva.sv
// Purpose: Wire checks on the serial control port between the host end and the device end.
// Assumes: Both ends share one clock and the power-on reset.
// Notes: Only the first frame after power-on is decoded, since later frames depend on the host's traffic.
`timescale 1ns/1ns
module seq_link_sva
    import seq_pkg::*;
#(
    parameter int unsigned EXIT_CYCLES = EXIT_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdin,
    input wire logic sdout
);
    logic [47:0] shift_q;
    logic [5:0] bits_q;
    logic [7:0] frames_q;
    logic [17:0] boot_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shift_q <= '0;
            bits_q <= '0;
        end else if (cs_n) begin
            bits_q <= '0;
        end else if ($rose(sclk)) begin
            shift_q <= {shift_q[46:0], sdin};
            bits_q <= bits_q + 6'h01;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frames_q <= '0;
        end else if ($rose(cs_n) && frames_q != 8'hFF) begin
            frames_q <= frames_q + 8'h01;
        end
    end
    // Saturating, so the boot window is judged against power-on only.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_q <= '0;
        end else if (boot_q < EXIT_CYCLES) begin
            boot_q <= boot_q + 18'h00001;
        end
    end
    property p_boot_quiet; boot_q < EXIT_CYCLES |-> cs_n && !sclk; endproperty
    property p_frame_len; $rose(cs_n) |-> bits_q == 6'd48; endproperty
    property p_first_frame;
        $rose(cs_n) && frames_q == 8'h00 |-> shift_q == {16'h0000, ADDR_EYE_CFG3, EYE_CFG3_BOOT_VALUE};
    endproperty
    property p_gap; $rose(cs_n) |=> cs_n [*8]; endproperty
    property p_sclk_high; $rose(sclk) |-> sclk [*8]; endproperty
    property p_sdin_hold; sclk && $past(sclk) |-> $stable(sdin); endproperty
    property p_idle; cs_n && $past(cs_n) |-> !sclk && sdin; endproperty
    property p_start; $fell(cs_n) |-> !sclk; endproperty
    property p_loop; cs_n [*8] |-> sdout; endproperty
    a_boot_quiet: assert property (p_boot_quiet) else $error("port active during boot");
    a_frame_len: assert property (p_frame_len) else $error("frame is not 48 bits");
    a_first_frame: assert property (p_first_frame) else $error("first frame is not the eye setup");
    a_gap: assert property (p_gap) else $error("gap between frames too short");
    a_sclk_high: assert property (p_sclk_high) else $error("serial clock high phase too short");
    a_sdin_hold: assert property (p_sdin_hold) else $error("data in moved while clock high");
    a_idle: assert property (p_idle) else $error("idle levels wrong");
    a_start: assert property (p_start) else $error("frame started with clock high");
    a_loop: assert property (p_loop) else $error("data out not idle high");
    c_frame: cover property ($rose(cs_n));
    c_boot_done: cover property (boot_q == EXIT_CYCLES && cs_n);
    c_first: cover property ($rose(cs_n) && frames_q == 8'h00);
endmodule : seq_link_sva

// ### verification/boot_and_soft_reset_sequencer_tb_top.sv
// Purpose: Runs boot, hold, release and pulse reset through the host end against the device end.
// Assumes: Both ends use a shortened exit delay.
// Notes: The host end owns the wire, so every stimulus is a user request or a soft reset request.
`timescale 1ns/1ns
module boot_and_soft_reset_sequencer_tb_top;
    import seq_pkg::*;
    localparam int unsigned EXIT_N = 200;
    logic clk_sys;
    logic rst;
    logic [UNIT_W-1:0] unit_id_cfg, unit_id;
    logic soft_reset_req, req_valid, req_rw, req_ready, resp_valid, resp_refused, dev_ready;
    logic core_rst, core_ready, link_disable, bus_through;
    logic [15:0] req_addr, req_wdata, resp_rdata, eye_cfg, rd;
    logic refused;
    logic cs_n_d;
    logic in_hold = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    int k;
    host_link_if link();
    seq_device_end #(.EXIT_CYCLES(EXIT_N)) seq_device_end_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
        .core_rst(core_rst), .core_ready(core_ready), .unit_id(unit_id), .link_disable(link_disable),
        .bus_through(bus_through), .eye_cfg(eye_cfg));
    seq_host_end #(.EXIT_CYCLES(EXIT_N)) seq_host_end_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
        .unit_id_cfg(unit_id_cfg), .soft_reset_req(soft_reset_req), .req_valid(req_valid),
        .req_ready(req_ready), .req_rw(req_rw), .req_addr(req_addr), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_refused(resp_refused), .resp_rdata(resp_rdata), .dev_ready(dev_ready));
    seq_link_sva #(.EXIT_CYCLES(EXIT_N)) seq_link_sva_inst (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk),
        .cs_n(link.cs_n), .sdin(link.sdin), .sdout(link.sdout));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // A wait loop that runs out is a hang on the far side, so it counts as a mismatch.
    task automatic hang_chk(input int lim);
        if (k >= lim) begin
            n_fail++;
            $display("[ERR] %0t wait limit reached", $time);
        end
    endtask : hang_chk
    task automatic access(input logic rw, input logic [15:0] addr, input logic [15:0] wdata);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_rw <= rw;
        req_addr <= addr;
        req_wdata <= wdata;
        @(negedge clk_sys);
        for (k = 0; k < 8000 && req_ready !== 1'b1; k++) @(negedge clk_sys);
        hang_chk(8000);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        @(negedge clk_sys);
        for (k = 0; k < 3000 && resp_valid !== 1'b1; k++) @(negedge clk_sys);
        hang_chk(3000);
        rd = resp_rdata;
        refused = resp_refused;
    endtask : access
    task automatic wait_ready();
        for (k = 0; k < 8000 && dev_ready !== 1'b1; k++) @(negedge clk_sys);
        hang_chk(8000);
    endtask : wait_ready
    // A frame may only start while the device is ready or deliberately held.
    always @(negedge clk_sys) begin
        cs_n_d <= link.cs_n;
        if (!rst && core_rst && !in_hold && cs_n_d && !link.cs_n) begin
            n_fail++;
            $display("[ERR] %0t frame started during boot", $time);
        end
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1;
        unit_id_cfg = 5'h00;
        soft_reset_req = 1'b0;
        req_valid = 1'b0;
        req_rw = 1'b0;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (k = 0; k < 1000 && core_ready !== 1'b1; k++) @(negedge clk_sys);
        check({15'h0000, k >= EXIT_N && k <= EXIT_N + 2}, 16'h0001);
        wait_ready();
        check(eye_cfg, EYE_CFG3_BOOT_VALUE);
        check({9'h000, bus_through, link_disable, unit_id}, 16'h0000);
        access(1'b0, 16'h0010, 16'h1234);
        access(1'b1, 16'h0010, 16'h0000);
        check(rd, 16'h1234);
        access(1'b1, ADDR_SOFT_RESET, 16'h0000);
        check(rd, RST_RELEASE);
        access(1'b0, ADDR_INTERNAL_LO, 16'hFFFF);
        check({15'h0000, refused}, 16'h0001);
        in_hold = 1'b1;
        access(1'b0, ADDR_SOFT_RESET, RST_HOLD);
        check({15'h0000, core_rst}, 16'h0001);
        access(1'b1, ADDR_SOFT_RESET, 16'h0000);
        check(rd, RST_HOLD);
        access(1'b0, 16'h0010, 16'h5555);
        access(1'b0, ADDR_SOFT_RESET, 16'h1234);
        check({15'h0000, core_rst}, 16'h0001);
        access(1'b0, ADDR_SOFT_RESET, RST_RELEASE);
        in_hold = 1'b0;
        check({15'h0000, core_ready}, 16'h0000);
        repeat (EXIT_N) @(posedge clk_sys);
        check({15'h0000, core_ready}, 16'h0001);
        access(1'b1, 16'h0010, 16'h0000);
        check(rd, 16'h0000);
        access(1'b0, 16'h0010, 16'hABCD);
        @(posedge clk_sys);
        unit_id_cfg <= 5'h05;
        soft_reset_req <= 1'b1;
        for (k = 0; k < 8000 && dev_ready !== 1'b0; k++) @(negedge clk_sys);
        hang_chk(8000);
        @(posedge clk_sys);
        soft_reset_req <= 1'b0;
        @(negedge clk_sys);
        wait_ready();
        check({9'h000, bus_through, link_disable, unit_id}, 16'h0005);
        check(eye_cfg, EYE_CFG3_BOOT_VALUE);
        access(1'b1, 16'h0010, 16'h0000);
        check(rd, 16'h0000);
        close_out();
    end
endmodule : boot_and_soft_reset_sequencer_tb_top
